// ==== hdl/fcep_host.sv ====
// Host sequencer driving a bulk-erase flash through its strobe pins
`timescale 1ns/1ps

// Overview of operation
// - Erase and program start only after two consecutive command writes.
// - Erase starts on the second of two erase arm writes.
// - Host times a 10 ms erase pulse before the erase check.
// - Erase check carries an address; host compares the byte with FFH.
// - After each good erase compare, check the next address in sequence.
// - Failed erase compare repeats erase, at most 1000 times.
// - Every byte is programmed before an erase is started.
// - Program is an arm write, then a write with address and data.
// - Host times a 10 us program pulse before the program check.
// - After a good program compare, an erase restarts the sequence for the next byte; a program command ends.
// - Failed program compare repeats that byte, at most 25 times.
module fcep_host
    import fcep_pkg::*;
#(
    parameter int ERASE_PULSE_CYCLES = ERASE_PULSE_CYC,
    parameter int ARRAY_SIZE = ARRAY_BYTES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // User command port
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [1:0] cmdOp,
    input wire logic [ADDR_W-1:0] cmdAddr,
    input wire logic [DATA_W-1:0] cmdData,
    output logic rspValid,
    output logic [DATA_W-1:0] rspData,
    output logic rspError,
    // Flash pins
    output logic [ADDR_W-1:0] addressLines,
    input wire logic [DATA_W-1:0] dataLinesIn,
    output logic [DATA_W-1:0] dataLinesOut,
    output logic dataLinesOeN,
    output logic chipSelectN,
    output logic writeStrobeN,
    output logic outputGateN,
    output logic vppOn
);
    fcep_alg_e algQ, algD;
    fcep_bus_e busQ, busD;
    logic [TIMER_W-1:0] timer_q;
    logic [BCNT_W-1:0] busCnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] pgmData_q;
    logic [DATA_W-1:0] rdData_q;
    logic [RETRY_W-1:0] retry_q;
    logic eraseOp_q;
    logic err_q;
    logic vpp_q;
    logic busDone_q;
    logic busWriting_q;
    logic [ADDR_W-1:0] addrPin_q;
    logic [DATA_W-1:0] dataPin_q;
    logic tLoad;
    logic [TIMER_W-1:0] tVal;
    logic tDone;
    logic algBus;
    logic busWrite;
    logic busGo;
    logic [DATA_W-1:0] busData;
    logic [DATA_W-1:0] wantByte;
    logic verifyOk;
    logic lastAddr;
    logic progGiveUp;
    logic eraseGiveUp;

    assign tDone = (timer_q == '0);
    assign algBus = (algQ == A_READ) || (algQ == A_PARM) || (algQ == A_PDATA)
        || (algQ == A_PCHK) || (algQ == A_PRD) || (algQ == A_EARM)
        || (algQ == A_EGO) || (algQ == A_ECHK) || (algQ == A_ERD);
    assign busWrite = !((algQ == A_READ) || (algQ == A_PRD) || (algQ == A_ERD));
    assign busGo = algBus && (busQ == B_IDLE) && !busDone_q;
    assign wantByte = (algQ == A_ERD) ? ERASED_BYTE : pgmData_q;
    assign verifyOk = (rdData_q == wantByte);
    assign lastAddr = (addr_q == ADDR_W'(ARRAY_SIZE - 1));
    assign progGiveUp = (retry_q == RETRY_W'(PROG_TRIES - 1));
    assign eraseGiveUp = (retry_q == RETRY_W'(ERASE_TRIES - 1));

    always_comb begin
        busData = '0;
        if (algQ == A_PARM) begin
            busData = CMD_PROG_ARM;
        end else if (algQ == A_PDATA) begin
            busData = pgmData_q;
        end else if (algQ == A_PCHK) begin
            busData = CMD_PROG_CHECK;
        end else if ((algQ == A_EARM) || (algQ == A_EGO)) begin
            busData = CMD_ERASE_ARM;
        end else if (algQ == A_ECHK) begin
            busData = CMD_ERASE_CHECK;
        end
    end

    // Operation sequencing
    always_comb begin
        algD = algQ;
        tLoad = 1'b0;
        tVal = '0;
        case (algQ)
            A_IDLE: begin
                if (cmdValid) begin
                    if (cmdOp == OP_PROGRAM || cmdOp == OP_ERASE) begin
                        algD = A_VPP;
                        tLoad = 1'b1;
                        tVal = TIMER_W'(VPP_SETUP_CYC);
                    end else begin
                        algD = A_READ;
                    end
                end
            end
            A_VPP: if (tDone) algD = A_PARM;
            A_READ: if (busDone_q) algD = A_DONE;
            A_PARM: if (busDone_q) algD = A_PDATA;
            A_PDATA: begin
                if (busDone_q) begin
                    algD = A_PWAIT;
                    tLoad = 1'b1;
                    tVal = TIMER_W'(PROG_PULSE_CYC);
                end
            end
            A_PWAIT: if (tDone) algD = A_PCHK;
            A_PCHK: begin
                if (busDone_q) begin
                    algD = A_PRCV;
                    tLoad = 1'b1;
                    tVal = TIMER_W'(RECOVERY_CYC);
                end
            end
            A_PRCV: if (tDone) algD = A_PRD;
            A_PRD: begin
                if (busDone_q) begin
                    if (verifyOk) begin
                        if (!eraseOp_q) algD = A_DONE;
                        else if (lastAddr) algD = A_EARM;
                        else algD = A_PARM;
                    end else begin
                        algD = progGiveUp ? A_DONE : A_PARM;
                    end
                end
            end
            A_EARM: if (busDone_q) algD = A_EGO;
            A_EGO: begin
                if (busDone_q) begin
                    algD = A_EWAIT;
                    tLoad = 1'b1;
                    tVal = TIMER_W'(ERASE_PULSE_CYCLES);
                end
            end
            A_EWAIT: if (tDone) algD = A_ECHK;
            A_ECHK: begin
                if (busDone_q) begin
                    algD = A_ERCV;
                    tLoad = 1'b1;
                    tVal = TIMER_W'(RECOVERY_CYC);
                end
            end
            A_ERCV: if (tDone) algD = A_ERD;
            A_ERD: begin
                if (busDone_q) begin
                    if (verifyOk) algD = lastAddr ? A_DONE : A_ECHK;
                    else algD = eraseGiveUp ? A_DONE : A_EARM;
                end
            end
            A_DONE: algD = A_IDLE;
            default: algD = A_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) algQ <= A_IDLE;
        else algQ <= algD;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) timer_q <= '0;
        else if (tLoad) timer_q <= tVal;
        else if (!tDone) timer_q <= timer_q - 1'b1;
    end

    // Operation context: cursor, data, retries, outcome
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            addr_q <= '0;
            pgmData_q <= '0;
            eraseOp_q <= 1'b0;
        end else if (algQ == A_IDLE && cmdValid) begin
            eraseOp_q <= (cmdOp == OP_ERASE);
            addr_q <= (cmdOp == OP_ERASE) ? '0 : cmdAddr;
            pgmData_q <= (cmdOp == OP_ERASE) ? PREPROG_BYTE : cmdData;
        end else if (busDone_q && verifyOk && eraseOp_q
                     && (algQ == A_PRD || algQ == A_ERD)) begin
            addr_q <= lastAddr ? '0 : addr_q + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) retry_q <= '0;
        else if (algQ == A_IDLE) retry_q <= '0;
        else if (busDone_q && algQ == A_PRD) retry_q <= verifyOk ? '0 : retry_q + 1'b1;
        else if (busDone_q && algQ == A_ERD && !verifyOk) retry_q <= retry_q + 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) err_q <= 1'b0;
        else if (algQ == A_IDLE) err_q <= 1'b0;
        else if (busDone_q && !verifyOk
                 && ((algQ == A_PRD && progGiveUp) || (algQ == A_ERD && eraseGiveUp)))
            err_q <= 1'b1;
    end

    // Supply held high only across program and erase operations
    always_ff @(posedge mclk) begin
        if (!rstn) vpp_q <= 1'b0;
        else if (algQ == A_IDLE && cmdValid && (cmdOp == OP_PROGRAM || cmdOp == OP_ERASE))
            vpp_q <= 1'b1;
        else if (algQ == A_DONE) vpp_q <= 1'b0;
    end

    // Pin cycle engine
    always_comb begin
        busD = busQ;
        case (busQ)
            B_IDLE: if (busGo) busD = busWrite ? B_SETUP : B_READ;
            B_SETUP: busD = B_STROBE;
            B_STROBE: if (busCnt_q == '0) busD = B_HOLD;
            B_HOLD: busD = B_IDLE;
            B_READ: if (busCnt_q == '0) busD = B_IDLE;
            default: busD = B_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) busQ <= B_IDLE;
        else busQ <= busD;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) busCnt_q <= '0;
        else if (busQ == B_SETUP) busCnt_q <= BCNT_W'(WRITE_PULSE_CYC - 1);
        else if (busGo && !busWrite) busCnt_q <= BCNT_W'(ACCESS_CYC - 1);
        else if (busCnt_q != '0) busCnt_q <= busCnt_q - 1'b1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) busDone_q <= 1'b0;
        else busDone_q <= (busQ == B_HOLD) || (busQ == B_READ && busCnt_q == '0);
    end

    // Address and data stay put from setup through hold
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            addrPin_q <= '0;
            dataPin_q <= '0;
            busWriting_q <= 1'b0;
        end else if (busGo) begin
            addrPin_q <= addr_q;
            dataPin_q <= busData;
            busWriting_q <= busWrite;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) rdData_q <= '0;
        else if (busQ == B_READ && busCnt_q == '0) rdData_q <= dataLinesIn;
    end

    assign addressLines = addrPin_q;
    assign dataLinesOut = dataPin_q;
    // Host releases the data lines before the gate opens, so no contention
    assign dataLinesOeN = !(busWriting_q && (busQ == B_STROBE || busQ == B_HOLD));
    assign chipSelectN = (busQ == B_IDLE);
    assign writeStrobeN = (busQ != B_STROBE);
    assign outputGateN = (busQ != B_READ);
    assign vppOn = vpp_q;

    assign cmdReady = (algQ == A_IDLE);
    assign rspValid = (algQ == A_DONE);
    assign rspData = rdData_q;
    assign rspError = err_q;
endmodule : fcep_host

// ==== hdl/fcep_pkg.sv ====
// Constants, timing and state encodings for the flash erase/program host sequencer
package fcep_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    localparam int TIMER_W = 20;
    localparam int RETRY_W = 10;
    localparam int BCNT_W = 4;

    localparam int CLK_PERIOD_NS = 20;

    // Least time in ns to whole clock cycles, never below one
    function automatic int fcepCycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : fcepCycles

    localparam int WRITE_PULSE_NS = 50;
    localparam int ACCESS_NS = 200;
    localparam int VPP_SETUP_NS = 100;
    localparam int RECOVERY_US = 6;
    localparam int PROG_PULSE_US = 10;
    localparam int ERASE_PULSE_MS = 10;
    localparam int WRITE_PULSE_CYC = fcepCycles(WRITE_PULSE_NS);
    localparam int ACCESS_CYC = fcepCycles(ACCESS_NS);
    localparam int VPP_SETUP_CYC = fcepCycles(VPP_SETUP_NS);
    localparam int RECOVERY_CYC = fcepCycles(RECOVERY_US * 1000);
    localparam int PROG_PULSE_CYC = fcepCycles(PROG_PULSE_US * 1000);
    localparam int ERASE_PULSE_CYC = fcepCycles(ERASE_PULSE_MS * 1000000);

    localparam int PROG_TRIES = 25;
    localparam int ERASE_TRIES = 1000;
    localparam int ARRAY_BYTES = 262144;

    localparam logic [DATA_W-1:0] CMD_ERASE_ARM = 8'h20;
    localparam logic [DATA_W-1:0] CMD_ERASE_CHECK = 8'ha0;
    localparam logic [DATA_W-1:0] CMD_PROG_ARM = 8'h40;
    localparam logic [DATA_W-1:0] CMD_PROG_CHECK = 8'hc0;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
    localparam logic [DATA_W-1:0] PREPROG_BYTE = 8'h00;

    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROGRAM = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;

    typedef enum logic [15:0] {
        A_IDLE  = 16'h0001,
        A_VPP   = 16'h0002,
        A_READ  = 16'h0004,
        A_PARM  = 16'h0008,
        A_PDATA = 16'h0010,
        A_PWAIT = 16'h0020,
        A_PCHK  = 16'h0040,
        A_PRCV  = 16'h0080,
        A_PRD   = 16'h0100,
        A_EARM  = 16'h0200,
        A_EGO   = 16'h0400,
        A_EWAIT = 16'h0800,
        A_ECHK  = 16'h1000,
        A_ERCV  = 16'h2000,
        A_ERD   = 16'h4000,
        A_DONE  = 16'h8000
    } fcep_alg_e;

    typedef enum logic [4:0] {
        B_IDLE   = 5'h01,
        B_SETUP  = 5'h02,
        B_STROBE = 5'h04,
        B_HOLD   = 5'h08,
        B_READ   = 5'h10
    } fcep_bus_e;
endpackage : fcep_pkg

// ==== testbench/fcep_host_props.sv ====
// Port assertions for the flash erase/program host sequencer
`timescale 1ns/1ps
module fcep_host_props
    import fcep_pkg::*;
#(
    parameter int ERASE_PULSE_CYCLES = ERASE_PULSE_CYC,
    parameter int ARRAY_SIZE = ARRAY_BYTES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Observed ports
    input wire logic rspValid,
    input wire logic [ADDR_W-1:0] addressLines,
    input wire logic [DATA_W-1:0] dataLinesOut,
    input wire logic dataLinesOeN,
    input wire logic chipSelectN,
    input wire logic writeStrobeN,
    input wire logic outputGateN,
    input wire logic vppOn
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Saturating so a long erase pulse never wraps the count
    logic [TIMER_W:0] gapQ;
    logic [DATA_W-1:0] lastWrQ;
    logic [DATA_W-1:0] prevWrQ;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            gapQ <= '0;
            lastWrQ <= 8'h00;
            prevWrQ <= 8'h00;
        end else if ($rose(writeStrobeN)) begin
            gapQ <= '0;
            lastWrQ <= dataLinesOut;
            prevWrQ <= lastWrQ;
        end else if (!gapQ[TIMER_W]) begin
            gapQ <= gapQ + 1'b1;
        end
    end
    sequence s_chk(logic [7:0] c);
        $fell(writeStrobeN) && dataLinesOut == c;
    endsequence
    a_no_contention: assert property (!dataLinesOeN |-> outputGateN && !chipSelectN)
        else $error("data driven outside a write");
    a_strobe_qual: assert property ($fell(writeStrobeN) |-> vppOn && outputGateN)
        else $error("strobe without supply or with gate low");
    a_strobe_width: assert property ($fell(writeStrobeN) |-> (!writeStrobeN)[*3] ##1 writeStrobeN)
        else $error("strobe low time wrong");
    a_addr_hold: assert property (!chipSelectN && !$past(chipSelectN) |-> $stable(addressLines))
        else $error("address moved while selected");
    a_data_hold: assert property (!dataLinesOeN && !$past(dataLinesOeN) |-> $stable(dataLinesOut))
        else $error("write data moved");
    a_read_gate: assert property (!outputGateN |-> !chipSelectN && writeStrobeN)
        else $error("gate low without a read");
    a_prog_pulse: assert property (s_chk(CMD_PROG_CHECK) |-> gapQ >= PROG_PULSE_CYC)
        else $error("program pulse too short");
    a_erase_pulse: assert property (s_chk(CMD_ERASE_CHECK) |->
        lastWrQ != CMD_ERASE_ARM || gapQ >= ERASE_PULSE_CYCLES) else $error("erase pulse too short");
    a_erase_pair: assert property (s_chk(CMD_ERASE_CHECK) |->
        lastWrQ != CMD_ERASE_ARM || prevWrQ == CMD_ERASE_ARM) else $error("single erase arm");
    c_done: cover property (rspValid);
    c_prog_check: cover property (s_chk(CMD_PROG_CHECK));
    c_erase_check: cover property (s_chk(CMD_ERASE_CHECK));
endmodule : fcep_host_props

bind fcep_host fcep_host_props #(
    .ERASE_PULSE_CYCLES(ERASE_PULSE_CYCLES),
    .ARRAY_SIZE(ARRAY_SIZE)
) u_props (
    .mclk(mclk), .rstn(rstn), .rspValid(rspValid), .addressLines(addressLines),
    .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN), .chipSelectN(chipSelectN),
    .writeStrobeN(writeStrobeN), .outputGateN(outputGateN), .vppOn(vppOn)
);

// ==== testbench/fcep_flash_model.sv ====
// Behavioural bulk-erase flash device facing the host sequencer
`timescale 1ns/1ps
module fcep_flash_model
    import fcep_pkg::*;
#(
    parameter int SIZE = 4
) (
    // Host pins
    input wire logic [ADDR_W-1:0] addressLines,
    input wire logic [DATA_W-1:0] dataLinesOut,
    input wire logic dataLinesOeN,
    input wire logic chipSelectN,
    input wire logic writeStrobeN,
    input wire logic outputGateN,
    input wire logic vppOn,
    // Resolved data wire
    output logic [DATA_W-1:0] dataLinesIn
);
    logic [DATA_W-1:0] memQ [SIZE];
    logic [DATA_W-1:0] lastQ;
    logic [ADDR_W-1:0] adrQ;
    // 0 read, 1 program armed, 2 erase armed, 3 erasing
    logic [1:0] modeQ;
    logic preprogOk;
    int progMiss, eraseMiss, progArms, eraseRuns, eraseChecks;
    wire devOn = !chipSelectN && !outputGateN;
    wire wrOn = !chipSelectN && !writeStrobeN && outputGateN && vppOn;
    wire [DATA_W-1:0] devQ = memQ[addressLines];
    initial begin
        foreach (memQ[i]) memQ[i] = ERASED_BYTE;
        lastQ = 8'h00;
        modeQ = 2'h0;
        preprogOk = 1'b1;
    end
    always @(negedge vppOn) modeQ = 2'h0;
    always @(devOn or devQ) if (devOn) lastQ = devQ;
    // Released wire shows the inverse of the last byte the device drove, never a lucky match
    assign dataLinesIn = !dataLinesOeN ? dataLinesOut : devOn ? devQ : ~lastQ;
    always @(posedge wrOn) adrQ = addressLines;
    always @(negedge wrOn) begin
        if (modeQ == 2'h1) begin
            if (progMiss > 0) progMiss--;
            else memQ[adrQ] = memQ[adrQ] & dataLinesOut;
            modeQ = 2'h0;
        end else if (dataLinesOut == CMD_PROG_ARM) begin
            modeQ = 2'h1;
            progArms++;
        end else if (dataLinesOut == CMD_ERASE_ARM && modeQ == 2'h2) begin
            modeQ = 2'h3;
            eraseRuns++;
            foreach (memQ[i]) if (memQ[i] !== PREPROG_BYTE) preprogOk = 1'b0;
        end else if (dataLinesOut == CMD_ERASE_ARM) begin
            modeQ = 2'h2;
        end else begin
            if (dataLinesOut == CMD_ERASE_CHECK) eraseChecks++;
            if (modeQ == 2'h3 && eraseMiss > 0) eraseMiss--;
            else if (modeQ == 2'h3) foreach (memQ[i]) memQ[i] = ERASED_BYTE;
            modeQ = 2'h0;
        end
    end
endmodule : fcep_flash_model

// ==== testbench/fcep_host_tb.sv ====
// Self-checking bench for the flash erase/program host sequencer
`timescale 1ns/1ps
module fcep_host_tb
    import fcep_pkg::*;
;
    localparam int SIZE = 4;
    logic mclk, rstn, cmdValid, cmdReady, rspValid, rspError, gotErr;
    logic [1:0] cmdOp;
    logic [ADDR_W-1:0] cmdAddr, addressLines;
    logic [DATA_W-1:0] cmdData, rspData, dataLinesIn, dataLinesOut, gotData;
    logic dataLinesOeN, chipSelectN, writeStrobeN, outputGateN, vppOn;
    int err_total, total_checks, base, runs;
    fcep_host #(.ERASE_PULSE_CYCLES(20), .ARRAY_SIZE(SIZE)) DUT (
        .mclk(mclk), .rstn(rstn), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
        .rspError(rspError), .addressLines(addressLines), .dataLinesIn(dataLinesIn),
        .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN), .chipSelectN(chipSelectN),
        .writeStrobeN(writeStrobeN), .outputGateN(outputGateN), .vppOn(vppOn));
    fcep_flash_model #(.SIZE(SIZE)) PART (
        .addressLines(addressLines), .dataLinesOut(dataLinesOut), .dataLinesOeN(dataLinesOeN),
        .chipSelectN(chipSelectN), .writeStrobeN(writeStrobeN), .outputGateN(outputGateN),
        .vppOn(vppOn), .dataLinesIn(dataLinesIn));
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chkInt(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            err_total++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, got);
        end
    endtask : chkInt
    task automatic run_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdAddr <= a;
        cmdData <= d;
        do @(negedge mclk); while (cmdReady !== 1'b1);
        @(posedge mclk);
        cmdValid <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (rspValid !== 1'b1 && n < 40000);
        gotData = rspData;
        gotErr = rspError;
        chkInt("response arrived", 1, int'(n < 40000));
    endtask : run_cmd
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic t_reset();
        @(posedge mclk);
        @(negedge mclk);
        chk8("select strobe gate", 8'h07, {5'h0, chipSelectN, writeStrobeN, outputGateN});
        chk8("oe supply ready", 8'h05, {5'h0, dataLinesOeN, vppOn, cmdReady});
        $display("reset test done");
    endtask : t_reset
    task automatic t_read();
        PART.memQ[2] = 8'h3c;
        run_cmd(OP_READ, 18'h2, 8'h00);
        chk8("read byte", 8'h3c, gotData);
        chk8("read error", 8'h00, {7'h0, gotErr});
        chk8("read supply", 8'h00, {7'h0, vppOn});
        run_cmd(2'h3, 18'h2, 8'h00);
        chk8("spare op byte", 8'h3c, gotData);
        chk8("spare op supply", 8'h00, {7'h0, vppOn});
        $display("read test done");
    endtask : t_read
    task automatic t_program();
        base = PART.progArms;
        run_cmd(OP_PROGRAM, 18'h1, 8'h5a);
        chk8("program verify", 8'h5a, gotData);
        chk8("stored byte", 8'h5a, PART.memQ[1]);
        chk8("neighbour byte", 8'hff, PART.memQ[0]);
        chkInt("program attempts", 1, PART.progArms - base);
        $display("program test done");
    endtask : t_program
    task automatic t_prog_fail();
        PART.progMiss = 1000;
        base = PART.progArms;
        run_cmd(OP_PROGRAM, 18'h0, 8'h0f);
        PART.progMiss = 0;
        chk8("limit error", 8'h01, {7'h0, gotErr});
        chkInt("limit attempts", PROG_TRIES, PART.progArms - base);
        chk8("unchanged byte", 8'hff, PART.memQ[0]);
        $display("program limit test done");
    endtask : t_prog_fail
    task automatic t_erase();
        PART.eraseMiss = 1;
        base = PART.eraseChecks;
        runs = PART.eraseRuns;
        run_cmd(OP_ERASE, 18'h0, 8'h00);
        chk8("erase error", 8'h00, {7'h0, gotErr});
        chk8("preprogrammed", 8'h01, {7'h0, PART.preprogOk});
        chkInt("erase runs", 2, PART.eraseRuns - runs);
        chkInt("erase checks", SIZE + 1, PART.eraseChecks - base);
        for (int i = 0; i < SIZE; i++) chk8("erased byte", ERASED_BYTE, PART.memQ[i]);
        $display("erase test done");
    endtask : t_erase
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        rstn = 1'b0;
        cmdValid = 1'b0;
        cmdOp = 2'h0;
        cmdAddr = '0;
        cmdData = 8'h00;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_read();
        t_program();
        t_prog_fail();
        t_erase();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        test_done();
    end
endmodule : fcep_host_tb
